//--- rtl/spc_regs.vh
`ifndef SPC_REGS_VH
`define SPC_REGS_VH

// Register byte offsets
`define SPC_OFS_STATUS     8'h00
`define SPC_OFS_CTRL_ONE   8'h04
`define SPC_OFS_CTRL_TWO   8'h08
`define SPC_OFS_DATA       8'h0c

// Status register fields
`define SPC_ST_ENABLE      15
`define SPC_ST_TX_FULL     1
`define SPC_ST_RX_FULL     0

// Control one fields
`define SPC_C1_CLK_DIS     12
`define SPC_C1_DOUT_DIS    11
`define SPC_C1_WORD16      10
`define SPC_C1_SAMPLE_END  9
`define SPC_C1_EDGE        8
`define SPC_C1_SEL_EN      7
`define SPC_C1_POLARITY    6
`define SPC_C1_MASTER      5
`define SPC_C1_SEC_LSB     2
`define SPC_C1_PRI_LSB     0

// Control two fields
`define SPC_C2_FRAMED      15
`define SPC_C2_SYNC_DIR    14
`define SPC_C2_SYNC_POL    13
`define SPC_C2_SYNC_EDGE   1
`define SPC_C2_BUF_MODE    0

// Reset values and writable masks
`define SPC_RST_STATUS     16'h0000
`define SPC_RST_CTRL_ONE   16'h0000
`define SPC_RST_CTRL_TWO   16'h0000
`define SPC_MASK_STATUS    16'h8000
`define SPC_MASK_CTRL_ONE  16'h1fff
`define SPC_MASK_CTRL_TWO  16'he003

// Word lengths in bits
`define SPC_BITS_BYTE      5'h08
`define SPC_BITS_WORD      5'h10

`endif

//--- rtl/spc_port.v
// Contract
// - Standard: write sets tx full, shift-load clears
// - Enhanced: tx full when last slot written
// - Standard: received word sets rx full, read clears
// - Enhanced: rx full when last slot filled
// - Master clock pin disable releases clock pin
// - Data-out disable releases serial data pin
// - Word size select: sixteen or eight bits
// - Master samples end or middle per phase
// - Clock edge bit picks data change edge
// - Clock edge ignored, zero, in framed modes
// - Slave select enable uses active-low select
// - Clock polarity sets idle and active levels
// - Master enable selects master or slave
// - Secondary divider: code 111 one, 000 eight
// - Primary divider: one, four, sixteen, sixty-four
// - Framed enable turns select into sync pulse
// - Sync direction: input slave, output master only with master enable set
// - Sync polarity: high or low active
// - Sync edge: with first bit or before
// - Buffer mode selects enhanced or single buffers
// - Enhanced mode gives eight-word transmit, receive FIFOs
// - Pins taken only while module enabled
`include "spc_regs.vh"

module spc_port #(
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        serial_clock_in,
  output wire        serial_clock_out,
  output wire        serial_clock_oe_n,
  input  wire        serial_in_pin,
  output wire        serial_out_pin,
  output wire        serial_out_oe_n,
  input  wire        select_sync_in,
  output wire        select_sync_out,
  output wire        select_sync_oe_n
);

  localparam ST_IDLE  = 3'b001;
  localparam ST_SYNC  = 3'b010;
  localparam ST_SHIFT = 3'b100;

  reg  [15:0]   status_ctl;
  reg  [15:0]   serial_port_control_one;
  reg  [15:0]   serial_port_control_two;

  reg  [15:0]   tx_mem [0:DEPTH-1];
  reg  [15:0]   rx_mem [0:DEPTH-1];
  reg  [AW-1:0] tx_wr;
  reg  [AW-1:0] tx_rd;
  reg  [AW:0]   tx_cnt;
  reg  [AW-1:0] rx_wr;
  reg  [AW-1:0] rx_rd;
  reg  [AW:0]   rx_cnt;

  reg  [2:0]    state;
  reg           half;
  reg  [4:0]    bit_cnt;
  reg  [15:0]   tx_shift;
  reg  [15:0]   rx_shift;
  reg  [9:0]    div_cnt;
  reg           act_q;
  reg           eng_pop;
  reg           eng_push;
  reg  [15:0]   eng_word;

  wire module_enable        = status_ctl[`SPC_ST_ENABLE];
  wire clock_pin_disable    = serial_port_control_one[`SPC_C1_CLK_DIS];
  wire data_out_pin_disable = serial_port_control_one[`SPC_C1_DOUT_DIS];
  wire word_size_select     = serial_port_control_one[`SPC_C1_WORD16];
  wire sample_phase         = serial_port_control_one[`SPC_C1_SAMPLE_END];
  wire clock_edge           = serial_port_control_one[`SPC_C1_EDGE];
  wire slave_select_enable  = serial_port_control_one[`SPC_C1_SEL_EN];
  wire clock_polarity       = serial_port_control_one[`SPC_C1_POLARITY];
  wire master_enable        = serial_port_control_one[`SPC_C1_MASTER];
  wire [2:0] secondary_divider = serial_port_control_one[`SPC_C1_SEC_LSB +: 3];
  wire [1:0] primary_divider   = serial_port_control_one[`SPC_C1_PRI_LSB +: 2];
  wire framed_mode_enable   = serial_port_control_two[`SPC_C2_FRAMED];
  wire sync_direction       = serial_port_control_two[`SPC_C2_SYNC_DIR];
  wire sync_polarity        = serial_port_control_two[`SPC_C2_SYNC_POL];
  wire sync_edge_select     = serial_port_control_two[`SPC_C2_SYNC_EDGE];
  wire buffer_mode_select   = serial_port_control_two[`SPC_C2_BUF_MODE];

  // Bus request is acted on at the edge where the master sees ack
  wire bus_go  = wb_cyc_i & wb_stb_i & wb_ack_o;
  wire bus_wr  = bus_go & wb_we_i;
  wire bus_rd  = bus_go & ~wb_we_i;
  wire hit_buf = (wb_adr_i == `SPC_OFS_DATA);

  // Capacity one in standard mode makes the FIFO a holding register
  wire [AW:0] capacity = buffer_mode_select ? DEPTH[AW:0] : {{AW{1'b0}}, 1'b1};
  wire tx_buffer_full_flag = (tx_cnt >= capacity);
  wire rx_buffer_full_flag = (rx_cnt >= capacity);
  wire tx_push = bus_wr & hit_buf & (|wb_sel_i[1:0]) & ~tx_buffer_full_flag;
  wire tx_pop  = eng_pop & (tx_cnt != {(AW+1){1'b0}});
  // Words arriving with the receive side full are dropped
  wire rx_push = eng_push & ~rx_buffer_full_flag;
  wire rx_pop  = bus_rd & hit_buf & (rx_cnt != {(AW+1){1'b0}});

  wire [15:0] rx_holding_reg = rx_mem[rx_rd];
  wire [15:0] tx_holding_reg = tx_mem[tx_rd];

  // Framed operation forces the data-change edge to its zero setting
  wire       edge_eff = clock_edge & ~framed_mode_enable;
  wire [4:0] nbits    = word_size_select ? `SPC_BITS_WORD : `SPC_BITS_BYTE;
  wire       last_bit = (bit_cnt == nbits - 5'h01);
  wire [15:0] rx_next = {rx_shift[14:0], serial_in_pin};
  wire [15:0] rx_word = word_size_select ? rx_next : {8'h00, rx_next[7:0]};

  // Clock half period is the product of both divider ratios
  wire [6:0] pri_ratio = 7'h01 << {~primary_divider, 1'b0};
  wire [3:0] sec_ratio = 4'h8 - {1'b0, secondary_divider};
  wire [9:0] div_ratio = {3'h0, pri_ratio} * {6'h00, sec_ratio};
  wire       tick      = (div_cnt >= div_ratio - 10'h001);

  // Slave-side clock edges relative to the active level
  wire act_now    = serial_clock_in ^ clock_polarity;
  wire lead_edge  = act_now & ~act_q;
  wire trail_edge = ~act_now & act_q;
  wire smp_edge   = edge_eff ? lead_edge : trail_edge;
  wire chg_edge   = edge_eff ? trail_edge : lead_edge;
  wire sync_seen  = (select_sync_in == sync_polarity);
  wire selected   = ~slave_select_enable | ~select_sync_in;
  wire running    = module_enable & (state != ST_IDLE);

  function [15:0] merge;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0]  sel;
    input [15:0] mask;
    begin
      merge[7:0]  = sel[0] ? ((new_v[7:0] & mask[7:0]) | (old_v[7:0] & ~mask[7:0])) : old_v[7:0];
      merge[15:8] = sel[1] ? ((new_v[15:8] & mask[15:8]) | (old_v[15:8] & ~mask[15:8])) : old_v[15:8];
    end
  endfunction

  // Bus slave: ack one cycle after the strobe, dropped the cycle after
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      status_ctl <= `SPC_RST_STATUS;
      serial_port_control_one <= `SPC_RST_CTRL_ONE;
      serial_port_control_two <= `SPC_RST_CTRL_TWO;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i & wb_stb_i & ~wb_ack_o) begin
        case (wb_adr_i)
          `SPC_OFS_STATUS: begin
            wb_dat_o <= {16'h0000, status_ctl[15:2], tx_buffer_full_flag, rx_buffer_full_flag};
          end
          `SPC_OFS_CTRL_ONE: begin
            wb_dat_o <= {16'h0000, serial_port_control_one};
          end
          `SPC_OFS_CTRL_TWO: begin
            wb_dat_o <= {16'h0000, serial_port_control_two};
          end
          `SPC_OFS_DATA: begin
            wb_dat_o <= {16'h0000, rx_holding_reg};
          end
          default: begin
            wb_dat_o <= 32'h0000_0000;
          end
        endcase
      end
      if (bus_wr) begin
        case (wb_adr_i)
          `SPC_OFS_STATUS: begin
            status_ctl <= merge(status_ctl, wb_dat_i[15:0], wb_sel_i[1:0], `SPC_MASK_STATUS);
          end
          `SPC_OFS_CTRL_ONE: begin
            serial_port_control_one <= merge(serial_port_control_one, wb_dat_i[15:0], wb_sel_i[1:0],
                                             `SPC_MASK_CTRL_ONE);
          end
          `SPC_OFS_CTRL_TWO: begin
            serial_port_control_two <= merge(serial_port_control_two, wb_dat_i[15:0], wb_sel_i[1:0],
                                             `SPC_MASK_CTRL_TWO);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Buffer storage; push and pop in one cycle keep the count
  always @(posedge sys_clk) begin
    if (tx_push) begin
      tx_mem[tx_wr] <= wb_dat_i[15:0];
    end
    if (rx_push) begin
      rx_mem[rx_wr] <= eng_word;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wr  <= {AW{1'b0}};
      tx_rd  <= {AW{1'b0}};
      tx_cnt <= {(AW+1){1'b0}};
      rx_wr  <= {AW{1'b0}};
      rx_rd  <= {AW{1'b0}};
      rx_cnt <= {(AW+1){1'b0}};
    end else begin
      if (tx_push) begin
        tx_wr <= tx_wr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (tx_pop) begin
        tx_rd <= tx_rd + {{(AW-1){1'b0}}, 1'b1};
      end
      if (tx_push & ~tx_pop) begin
        tx_cnt <= tx_cnt + {{AW{1'b0}}, 1'b1};
      end else if (tx_pop & ~tx_push) begin
        tx_cnt <= tx_cnt - {{AW{1'b0}}, 1'b1};
      end
      if (rx_push) begin
        rx_wr <= rx_wr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (rx_pop) begin
        rx_rd <= rx_rd + {{(AW-1){1'b0}}, 1'b1};
      end
      if (rx_push & ~rx_pop) begin
        rx_cnt <= rx_cnt + {{AW{1'b0}}, 1'b1};
      end else if (rx_pop & ~rx_push) begin
        rx_cnt <= rx_cnt - {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // Half-bit divider runs only while a master frame is in progress
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 10'h000;
    end else if (!running || !master_enable || tick) begin
      div_cnt <= 10'h000;
    end else begin
      div_cnt <= div_cnt + 10'h001;
    end
  end

  // Shift engine; one state register serves both roles
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_IDLE;
      half     <= 1'b0;
      bit_cnt  <= 5'h00;
      tx_shift <= 16'h0000;
      rx_shift <= 16'h0000;
      act_q    <= 1'b0;
      eng_pop  <= 1'b0;
      eng_push <= 1'b0;
      eng_word <= 16'h0000;
    end else begin
      act_q    <= act_now;
      eng_pop  <= 1'b0;
      eng_push <= 1'b0;
      if (!module_enable) begin
        state   <= ST_IDLE;
        half    <= 1'b0;
        bit_cnt <= 5'h00;
      end else if (master_enable) begin
        case (state)
          ST_IDLE: begin
            // Sync input gates the start when another party frames
            if ((tx_cnt != {(AW+1){1'b0}}) && !eng_pop &&
                (!framed_mode_enable || !sync_direction || sync_seen)) begin
              tx_shift <= tx_holding_reg;
              eng_pop  <= 1'b1;
              bit_cnt  <= 5'h00;
              half     <= 1'b0;
              state    <= (framed_mode_enable && !sync_edge_select) ? ST_SYNC : ST_SHIFT;
            end
          end
          ST_SYNC: begin
            if (tick) begin
              half <= ~half;
              if (half) begin
                state <= ST_SHIFT;
              end
            end
          end
          ST_SHIFT: begin
            if (tick) begin
              half <= ~half;
              if (!half) begin
                if (!sample_phase) begin
                  rx_shift <= rx_next;
                end
              end else begin
                if (sample_phase) begin
                  rx_shift <= rx_next;
                end
                if (last_bit) begin
                  eng_push <= 1'b1;
                  eng_word <= sample_phase ? rx_word :
                              (word_size_select ? rx_shift : {8'h00, rx_shift[7:0]});
                  state    <= ST_IDLE;
                end else begin
                  tx_shift <= {tx_shift[14:0], 1'b0};
                  bit_cnt  <= bit_cnt + 5'h01;
                end
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end else begin
        case (state)
          ST_IDLE: begin
            bit_cnt <= 5'h00;
            if (framed_mode_enable ? sync_seen : selected) begin
              tx_shift <= (tx_cnt != {(AW+1){1'b0}}) ? tx_holding_reg : 16'h0000;
              eng_pop  <= ~eng_pop;
              state    <= (framed_mode_enable && !sync_edge_select) ? ST_SYNC : ST_SHIFT;
            end
          end
          ST_SYNC: begin
            if (smp_edge) begin
              state <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            if (!framed_mode_enable && !selected) begin
              state <= ST_IDLE;
            end else if (smp_edge) begin
              rx_shift <= rx_next;
              if (last_bit) begin
                eng_push <= 1'b1;
                eng_word <= rx_word;
                state    <= ST_IDLE;
              end else begin
                bit_cnt <= bit_cnt + 5'h01;
              end
            end else if (chg_edge && (bit_cnt != 5'h00)) begin
              tx_shift <= {tx_shift[14:0], 1'b0};
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Clock is active in the first half when edge is zero, second when one
  wire clk_active = ((state == ST_SHIFT) || (state == ST_SYNC)) && (half == edge_eff);
  assign serial_clock_out  = clk_active ^ clock_polarity;
  assign serial_clock_oe_n = ~(module_enable & master_enable & ~clock_pin_disable);

  assign serial_out_pin  = word_size_select ? tx_shift[15] : tx_shift[7];
  assign serial_out_oe_n = ~(module_enable & ~data_out_pin_disable);

  // Sync pulse lasts one bit time, before or with the first bit
  wire sync_pulse = (state == ST_SYNC) ||
                    ((state == ST_SHIFT) && sync_edge_select && (bit_cnt == 5'h00));
  assign select_sync_out  = sync_pulse ? sync_polarity : ~sync_polarity;
  assign select_sync_oe_n = ~(module_enable & master_enable & framed_mode_enable & ~sync_direction);

endmodule

//--- sim/spc_port_monitor.sv
module spc_port_monitor (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        serial_clock_out,
  input wire        serial_clock_oe_n,
  input wire        serial_out_oe_n,
  input wire        select_sync_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        en;
  logic [15:0] c1;
  logic [15:0] c2;

  // Shadow of the control bits, taken at the edge where the write lands
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en <= 1'b0;
      c1 <= 16'h0000;
      c2 <= 16'h0000;
    end else if (wb_ack_o && wb_we_i) begin
      if (wb_adr_i == 8'h00)
        en <= wb_dat_i[15];
      if (wb_adr_i == 8'h04)
        c1 <= wb_dat_i[15:0] & 16'h1fff;
      if (wb_adr_i == 8'h08)
        c2 <= wb_dat_i[15:0] & 16'he003;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  ctrl_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |-> wb_dat_o == {16'h0000, c1})
    else $error("control one read back wrong");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h0f |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  clk_pin_a: assert property (serial_clock_oe_n == !(en && c1[5] && !c1[12]))
    else $error("clock pin enable wrong");
  dout_pin_a: assert property (serial_out_oe_n == !(en && !c1[11]))
    else $error("data pin enable wrong");
  sync_pin_a: assert property (select_sync_oe_n == !(en && c1[5] && c2[15] && !c2[14]))
    else $error("sync pin enable wrong");
  clk_half_a: assert property ($rose(serial_clock_out) && en && c1[6:0] == 7'h3b
    |=> !$fell(serial_clock_out) ##1 $fell(serial_clock_out))
    else $error("clock half period wrong");
endmodule

bind spc_port spc_port_monitor i_mon (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .serial_clock_out(serial_clock_out),
  .serial_clock_oe_n(serial_clock_oe_n),
  .serial_out_oe_n(serial_out_oe_n),
  .select_sync_oe_n(select_sync_oe_n)
);

//--- sim/spc_slave_model.sv
module spc_slave_model (
  input  wire         ss_n,
  input  wire         sys_clk,
  input  wire         sclk,
  input  wire         mosi,
  input  wire         word16,
  input  wire  [15:0] reply,
  output logic        miso,
  output logic [15:0] got,
  output int          nwords
);
  timeunit 1ns;
  timeprecision 1ps;
  int          bitn;
  logic [15:0] sh;
  logic [15:0] tx;

  initial begin
    miso = 1'b0;
    got = 16'h0000;
    nwords = 0;
    bitn = 0;
    sh = 16'h0000;
  end
  // Idle-low clock, data changes on the leading edge
  always @(posedge sclk) begin
    if (!ss_n) begin
      if (bitn == 0)
        tx = reply + nwords[15:0];
      miso <= tx[(word16 ? 15 : 7) - bitn];
    end
  end
  // Last bit is held to the next word, so end-of-bit sampling still sees it
  always @(negedge sclk) begin
    if (!ss_n) begin
      sh = {sh[14:0], mosi};
      if (bitn == (word16 ? 15 : 7)) begin
        got <= word16 ? sh : {8'h00, sh[7:0]};
        nwords <= nwords + 1;
        bitn <= 0;
      end else
        bitn <= bitn + 1;
    end
  end
  // Released line must not keep the last bit
  always @(posedge sys_clk) begin
    if (ss_n)
      miso <= ~miso;
    if (ss_n)
      bitn <= 0;
  end
endmodule

//--- sim/spc_port_tb_top.sv
`include "spc_regs.vh"

module spc_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] dati;
  wire  [31:0] dato;
  wire         ack;
  wire         sck;
  wire         sck_oe_n;
  wire         sdo;
  wire         sdo_oe_n;
  wire         sdi;
  wire         sso_oe_n;
  wire         sso;
  wire  [15:0] got;
  int          nw;
  logic        ss_n;
  logic        w16;
  logic [15:0] rep;
  logic [31:0] seed;
  logic [15:0] q;
  int          err_total;
  int          n_checks;
  logic [15:0] exp_tx[$];
  logic [15:0] exp_rx[$];
  logic [15:0] c1t[5] = '{16'h1020, 16'h0820, 16'h0020, 16'h0020, 16'h0060};
  logic [15:0] c2t[5] = '{16'h0000, 16'h0000, 16'ha000, 16'hc000, 16'h0000};
  logic [2:0]  pint[5] = '{3'b101, 3'b011, 3'b000, 3'b001, 3'b001};

  spc_port i_dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(4'h3),
    .wb_dat_i(dati),
    .wb_dat_o(dato),
    .wb_ack_o(ack),
    .serial_clock_in(1'b0),
    .serial_clock_out(sck),
    .serial_clock_oe_n(sck_oe_n),
    .serial_in_pin(sdi),
    .serial_out_pin(sdo),
    .serial_out_oe_n(sdo_oe_n),
    .select_sync_in(1'b1),
    .select_sync_out(sso),
    .select_sync_oe_n(sso_oe_n)
  );
  spc_slave_model i_peer (
    .ss_n(ss_n),
    .sys_clk(sys_clk),
    .sclk(sck),
    .mosi(sdo),
    .word16(w16),
    .reply(rep),
    .miso(sdi),
    .got(got),
    .nwords(nw)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [15:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int t;
    t = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dati <= {16'h0000, d};
    do begin
      @(posedge sys_clk);
      t++;
    end while (ack !== 1'b1 && t < 40);
    q = dato[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    chk({15'h0000, t < 40}, 16'h0001, "bus answer");
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input string m);
    wb(1'b0, a, 16'h0000);
    chk(q, e, m);
  endtask
  task automatic send(input logic [15:0] d);
    wb(1'b1, `SPC_OFS_DATA, d);
    exp_tx.push_back(d & (w16 ? 16'hffff : 16'h00ff));
  endtask
  // Enable, let the port clock everything out to the far side, then deselect it
  task automatic run();
    int t;
    t = 0;
    ss_n <= 1'b0;
    wb(1'b1, `SPC_OFS_STATUS, 16'h8000);
    while (exp_tx.size() > 0 && t < 3000) begin
      @(posedge sys_clk);
      t++;
    end
    repeat (4) @(posedge sys_clk);
    ss_n <= 1'b1;
    chk({15'h0000, t < 3000}, 16'h0001, "transfer done");
  endtask
  task automatic pull(input int n);
    repeat (n) rd(`SPC_OFS_DATA, exp_rx.pop_front(), "received word");
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(nw) begin
    if (nw > 0) begin
      chk(got, exp_tx.pop_front(), "word on the wire");
      exp_rx.push_back((rep + nw[15:0] - 16'h0001) & (w16 ? 16'hffff : 16'h00ff));
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dati = 32'h0;
    ss_n = 1'b1;
    w16 = 1'b1;
    rep = 16'h0000;
    seed = 32'hefd5e660;
    err_total = 0;
    n_checks = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`SPC_OFS_STATUS, `SPC_RST_STATUS, "status reset");
    rd(`SPC_OFS_CTRL_ONE, `SPC_RST_CTRL_ONE, "ctrl one reset");
    rd(`SPC_OFS_CTRL_TWO, `SPC_RST_CTRL_TWO, "ctrl two reset");
    rd(8'h10, 16'h0000, "unmapped read");
    chk({13'h0000, sck_oe_n, sdo_oe_n, sso_oe_n}, 16'h0007, "pins released");
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      wb(1'b1, `SPC_OFS_CTRL_ONE, seed[15:0]);
      rd(`SPC_OFS_CTRL_ONE, seed[15:0] & `SPC_MASK_CTRL_ONE, "ctrl one");
      wb(1'b1, `SPC_OFS_CTRL_TWO, seed[31:16]);
      rd(`SPC_OFS_CTRL_TWO, seed[31:16] & `SPC_MASK_CTRL_TWO, "ctrl two");
    end
    // Park in master mode: random settings could start a slave frame on enable
    wb(1'b1, `SPC_OFS_CTRL_ONE, 16'h0020);
    wb(1'b1, `SPC_OFS_STATUS, 16'h8000);
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, `SPC_OFS_CTRL_TWO, c2t[i]);
      wb(1'b1, `SPC_OFS_CTRL_ONE, c1t[i]);
      @(posedge sys_clk);
      chk({13'h0000, sck_oe_n, sdo_oe_n, sso_oe_n}, {13'h0000, pint[i]}, "pin enables");
      chk({15'h0000, sso}, {15'h0000, ~c2t[i][13]}, "sync idle level");
    end
    chk({15'h0000, sck}, 16'h0001, "idle clock level");
    wb(1'b1, `SPC_OFS_CTRL_TWO, 16'h0000);
    for (int m = 1; m >= 0; m--) begin
      w16 = m[0];
      wb(1'b1, `SPC_OFS_STATUS, 16'h0000);
      wb(1'b1, `SPC_OFS_CTRL_ONE, {5'h00, m[0], ~m[0], 9'h03b});
      seed = xs(seed);
      rep = seed[31:16];
      send(seed[15:0]);
      rd(`SPC_OFS_STATUS, 16'h0002, "tx full set");
      run();
      rd(`SPC_OFS_STATUS, 16'h8001, "rx full set");
      pull(1);
      rd(`SPC_OFS_STATUS, 16'h8000, "rx full clear");
    end
    wb(1'b1, `SPC_OFS_STATUS, 16'h0000);
    wb(1'b1, `SPC_OFS_CTRL_TWO, 16'h0001);
    for (int i = 0; i < 9; i++) begin
      seed = xs(seed);
      if (i < 8)
        send(seed[15:0]);
      else
        wb(1'b1, `SPC_OFS_DATA, seed[15:0]);
      rd(`SPC_OFS_STATUS, (i >= 7) ? 16'h0002 : 16'h0000, "tx fill");
    end
    run();
    rd(`SPC_OFS_STATUS, 16'h8001, "rx filled");
    pull(1);
    rd(`SPC_OFS_STATUS, 16'h8000, "rx slot free");
    pull(7);
    test_done();
  end
endmodule
